/* core/rcd_diag_regs.sv */
`timescale 1ns/1ps
`include "rcd_params.svh"
// How it works
// - signal-detect live state reads at status bit 5.
// - clock-recovery lock live state reads at status bit 4.
// - lock rising edge sets sticky flag when enabled; read clears it.
// - any signal-detect change sets sticky flag when enabled; read clears it.
// - eye opening below post-lock limits sets sticky clear-on-read flag when enabled.
// - two 4-bit post-lock limits, vertical high nibble, step four counts.
// - tap 5 polarity at bit 4, weight at bits 3..0, read only.
// - enable bit 6 turns the pattern checker on.
// - enable bit 5 runs the pattern generator.
// - enable bit 3 demands comma checking before lock is declared.
// - enable bits 1 and 0 gate the lock and signal-change flags.
// - 16-bit generator pattern from two write-only bytes.
// - continuous adaption retriggers when eye moves beyond 4-bit change limits.
// - continuous adaption keeps feedback equalizer adapting after lock, else frozen.
// - either-eye option triggers adaption when either measure moves beyond its change limit.
// - skip bit ignores eye lock checks during continuous adaption.
// - hold bit freezes both counters; else they count when checker configured.
// - clear bit holds both counters at zero until written back to 0.
// - pattern force locks checker to chosen PRBS-7/9/15/31, else auto.
// - polarity force locks checker to chosen polarity, else auto.
// - 11-bit error count, bits 10..8 then bits 7..0.
// - 47-bit compared-bit count, most significant bits at lowest offset.
module rcd_diag_regs #(
  parameter int ERR_W = 11,
  parameter int BITS_W = 47
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port from the management interface
  input wire rcd_pkg::rcd_req_type req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // analog status pins
  input wire logic signal_present_i,
  input wire logic recovery_locked_i,
  input wire logic eye_loss_flag_on_i,
  // on-clock observation from equalizer and eye monitor
  input wire rcd_pkg::rcd_eye_type eye_i,
  input wire rcd_pkg::rcd_tap5_type tap5_i,
  input wire logic [7:0] eye_center_i,
  // pattern checker events
  input wire logic checker_synced_i,
  input wire logic bit_compared_i,
  input wire logic bit_mismatch_i,
  // controls
  output rcd_pkg::rcd_checker_type checker_o,
  output logic generator_on_o,
  output logic [15:0] user_pattern_word_o,
  output logic comma_lock_check_on_o,
  output logic adapt_allowed_o,
  output logic adapt_trigger_o,
  output logic skip_eye_checks_o
);
  logic [1:0] sig_sync_reg;
  logic [1:0] lock_sync_reg;
  logic [1:0] eyeon_sync_reg;
  logic sig_prev_reg;
  logic lock_prev_reg;
  logic [7:0] eye_thr_reg;
  logic [7:0] sbt_thr_reg;
  logic [7:0] enables_reg;
  logic [7:0] sel_a_reg;
  logic [7:0] sel_d_reg;
  logic [7:0] chg_lim_reg;
  logic [7:0] tap_lim_reg;
  logic [7:0] adapt_ctl_reg;
  logic [7:0] chk_ctl_reg;
  logic [15:0] pattern_reg;
  logic lock_gained_flag_reg;
  logic signal_change_flag_reg;
  logic eye_loss_flag_reg;
  logic eye_low_prev_reg;
  logic [7:0] base_h_reg;
  logic [7:0] base_v_reg;
  logic [ERR_W-1:0] mismatch_total_reg;
  logic [BITS_W-1:0] compared_bits_total_reg;
  logic sig_now;
  logic lock_now;
  logic wr_en;
  logic status_read;
  logic eye_low;
  logic eye_low_ok;
  logic h_moved;
  logic v_moved;
  logic adapt_next;
  logic count_ok;
  logic [7:0] rd_next;
  logic [8:0] h_diff;
  logic [8:0] v_diff;
  logic [7:0] h_floor;
  logic [7:0] v_floor;

  assign sig_now = sig_sync_reg[1];
  assign lock_now = lock_sync_reg[1];
  assign wr_en = req_i.wr;
  assign status_read = req_i.rd && (req_i.addr == `RCD_ADDR_INT_STAT);

  // pins cross in through two flops; only the second is ever looked at
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sig_sync_reg <= 2'h0;
      lock_sync_reg <= 2'h0;
      eyeon_sync_reg <= 2'h0;
    end else begin
      sig_sync_reg <= {sig_sync_reg[0], signal_present_i};
      lock_sync_reg <= {lock_sync_reg[0], recovery_locked_i};
      eyeon_sync_reg <= {eyeon_sync_reg[0], eye_loss_flag_on_i};
    end
  end

  // previous levels reset to the pins' idle level, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sig_prev_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      sig_prev_reg <= sig_now;
      lock_prev_reg <= lock_now;
    end
  end

  // writable registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      eye_thr_reg <= `RCD_RST_EYE_THR;
      sbt_thr_reg <= `RCD_RST_SBT_THR;
      enables_reg <= `RCD_RST_ENABLES;
      sel_a_reg <= 8'h00;
      sel_d_reg <= 8'h00;
      chg_lim_reg <= `RCD_RST_CHG_LIM;
      tap_lim_reg <= `RCD_RST_TAP_LIM;
      adapt_ctl_reg <= `RCD_RST_ADAPT_CTL;
      chk_ctl_reg <= `RCD_RST_CHK_CTL;
      pattern_reg <= 16'h0000;
    end else if (wr_en) begin
      unique case (req_i.addr)
        `RCD_ADDR_EYE_THR: eye_thr_reg <= req_i.wdata;
        `RCD_ADDR_SBT_THR: sbt_thr_reg <= req_i.wdata;
        `RCD_ADDR_ENABLES: begin
          enables_reg <= (req_i.wdata & `RCD_ENABLES_WMASK) |
                         (enables_reg & ~`RCD_ENABLES_WMASK);
        end
        `RCD_ADDR_SEL_A: sel_a_reg <= req_i.wdata;
        `RCD_ADDR_SEL_D: sel_d_reg <= req_i.wdata;
        `RCD_ADDR_PAT_LOW: pattern_reg[7:0] <= req_i.wdata;
        `RCD_ADDR_PAT_HIGH: pattern_reg[15:8] <= req_i.wdata;
        `RCD_ADDR_CHG_LIM: chg_lim_reg <= req_i.wdata;
        `RCD_ADDR_TAP_LIM: tap_lim_reg <= req_i.wdata;
        `RCD_ADDR_ADAPT_CTL: adapt_ctl_reg <= req_i.wdata;
        `RCD_ADDR_CHK_CTL: chk_ctl_reg <= req_i.wdata;
        default: begin
        end
      endcase
    end
  end

  // eye below post-lock limits, each limit step worth four counts
  assign h_floor = {2'b00, eye_thr_reg[3:0], 2'b00};
  assign v_floor = {2'b00, eye_thr_reg[7:4], 2'b00};
  assign eye_low = lock_now &&
                   ((eye_i.horizontal_eye_opening < h_floor) ||
                    (eye_i.vertical_eye_opening < v_floor));
  // eye checks are ignored while continuous adaption is allowed to skip them
  assign eye_low_ok = eye_low && !skip_eye_checks_o;

  // sticky flags: a read clears after its data is captured; a set wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lock_gained_flag_reg <= 1'b0;
    end else if (enables_reg[`RCD_EN_LOCK_FLAG] && lock_now && !lock_prev_reg) begin
      lock_gained_flag_reg <= 1'b1;
    end else if (status_read) begin
      lock_gained_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      signal_change_flag_reg <= 1'b0;
    end else if (enables_reg[`RCD_EN_SIG_FLAG] && (sig_now != sig_prev_reg)) begin
      signal_change_flag_reg <= 1'b1;
    end else if (status_read) begin
      signal_change_flag_reg <= 1'b0;
    end
  end

  // edge-triggered so a lasting low eye does not refill the flag after every read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      eye_low_prev_reg <= 1'b0;
    end else begin
      eye_low_prev_reg <= eye_low_ok;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      eye_loss_flag_reg <= 1'b0;
    end else if (eyeon_sync_reg[1] && eye_low_ok && !eye_low_prev_reg) begin
      eye_loss_flag_reg <= 1'b1;
    end else if (status_read) begin
      eye_loss_flag_reg <= 1'b0;
    end
  end

  // continuous adaption: compare against the eye seen at the last adaption
  assign h_diff = (eye_i.horizontal_eye_opening >= base_h_reg) ?
                  {1'b0, eye_i.horizontal_eye_opening - base_h_reg} :
                  {1'b0, base_h_reg - eye_i.horizontal_eye_opening};
  assign v_diff = (eye_i.vertical_eye_opening >= base_v_reg) ?
                  {1'b0, eye_i.vertical_eye_opening - base_v_reg} :
                  {1'b0, base_v_reg - eye_i.vertical_eye_opening};
  assign h_moved = h_diff > {5'h00, chg_lim_reg[7:4]};
  assign v_moved = v_diff > {5'h00, chg_lim_reg[3:0]};
  always_comb begin
    adapt_next = 1'b0;
    if (lock_now && adapt_ctl_reg[`RCD_AC_KEEP_ADAPT] && !adapt_trigger_o) begin
      if (adapt_ctl_reg[`RCD_AC_EITHER_EYE]) begin
        adapt_next = h_moved || v_moved;
      end else begin
        adapt_next = h_moved && v_moved;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      adapt_trigger_o <= 1'b0;
      adapt_allowed_o <= 1'b1;
      skip_eye_checks_o <= 1'b0;
    end else begin
      adapt_trigger_o <= adapt_next;
      // frozen after lock unless continuous adaption is on
      adapt_allowed_o <= !lock_now || adapt_ctl_reg[`RCD_AC_KEEP_ADAPT];
      skip_eye_checks_o <= adapt_ctl_reg[`RCD_AC_SKIP_EYE] &&
                           adapt_ctl_reg[`RCD_AC_KEEP_ADAPT] && lock_now;
    end
  end

  // base moves only at lock and at a trigger, so slow drift still fires once it adds up past the limits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      base_h_reg <= 8'h00;
      base_v_reg <= 8'h00;
    end else if ((lock_now && !lock_prev_reg) || adapt_next) begin
      base_h_reg <= eye_i.horizontal_eye_opening;
      base_v_reg <= eye_i.vertical_eye_opening;
    end
  end

  // pattern counters saturate rather than wrap, so a long run never reads small
  assign count_ok = enables_reg[`RCD_EN_CHECKER] && checker_synced_i &&
                    !chk_ctl_reg[`RCD_CC_HOLD];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || chk_ctl_reg[`RCD_CC_CLEAR]) begin
      mismatch_total_reg <= '0;
      compared_bits_total_reg <= '0;
    end else if (count_ok && bit_compared_i) begin
      if (!(&compared_bits_total_reg)) begin
        compared_bits_total_reg <= compared_bits_total_reg + 1'b1;
      end
      if (bit_mismatch_i && !(&mismatch_total_reg)) begin
        mismatch_total_reg <= mismatch_total_reg + 1'b1;
      end
    end
  end

  // read data; unmapped, reserved and write-only offsets read zero
  always_comb begin
    unique case (req_i.addr)
      `RCD_ADDR_TAP5: rd_next = {3'h0, tap5_i};
      `RCD_ADDR_EYE_THR: rd_next = eye_thr_reg;
      `RCD_ADDR_SBT_THR: rd_next = sbt_thr_reg;
      `RCD_ADDR_INT_STAT: begin
        rd_next = {2'h0, sig_now, lock_now, lock_gained_flag_reg,
                   signal_change_flag_reg, 1'b0, eye_loss_flag_reg};
      end
      `RCD_ADDR_ENABLES: rd_next = enables_reg;
      `RCD_ADDR_SEL_A: rd_next = sel_a_reg;
      `RCD_ADDR_SEL_D: rd_next = sel_d_reg;
      `RCD_ADDR_CHG_LIM: rd_next = chg_lim_reg;
      `RCD_ADDR_TAP_LIM: rd_next = tap_lim_reg;
      `RCD_ADDR_ADAPT_CTL: rd_next = adapt_ctl_reg;
      `RCD_ADDR_EYE_CTR: rd_next = eye_center_i;
      `RCD_ADDR_CHK_CTL: rd_next = chk_ctl_reg;
      `RCD_ADDR_ERR_HI: rd_next = {5'h00, mismatch_total_reg[10:8]};
      `RCD_ADDR_ERR_LO: rd_next = mismatch_total_reg[7:0];
      `RCD_ADDR_BITS_B5: rd_next = {1'b0, compared_bits_total_reg[46:40]};
      `RCD_ADDR_BITS_B4: rd_next = compared_bits_total_reg[39:32];
      `RCD_ADDR_BITS_B3: rd_next = compared_bits_total_reg[31:24];
      `RCD_ADDR_BITS_B2: rd_next = compared_bits_total_reg[23:16];
      `RCD_ADDR_BITS_B1: rd_next = compared_bits_total_reg[15:8];
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
    end
  end

  // read data holds until the next read, so a slow master may pick it up late
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (req_i.rd) begin
      rd_data_o <= rd_next;
    end
  end

  // control outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      checker_o <= '0;
    end else begin
      checker_o.checker_on <= enables_reg[`RCD_EN_CHECKER];
      checker_o.pattern_force <= chk_ctl_reg[`RCD_CC_PAT_FORCE];
      checker_o.pattern_choice <= chk_ctl_reg[3:2];
      checker_o.polarity_force <= chk_ctl_reg[`RCD_CC_POL_FORCE];
      checker_o.polarity_choice <= chk_ctl_reg[`RCD_CC_POL_CHOICE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      generator_on_o <= 1'b0;
      comma_lock_check_on_o <= 1'b0;
      user_pattern_word_o <= 16'h0000;
    end else begin
      generator_on_o <= enables_reg[`RCD_EN_GENERATOR];
      comma_lock_check_on_o <= enables_reg[`RCD_EN_COMMA];
      user_pattern_word_o <= pattern_reg;
    end
  end
endmodule : rcd_diag_regs

/* core/rcd_params.svh */
`ifndef RCD_PARAMS_SVH
`define RCD_PARAMS_SVH
// register offsets
`define RCD_ADDR_TAP5 8'h75
`define RCD_ADDR_EYE_THR 8'h76
`define RCD_ADDR_SBT_THR 8'h77
`define RCD_ADDR_INT_STAT 8'h78
`define RCD_ADDR_ENABLES 8'h79
`define RCD_ADDR_SEL_A 8'h7A
`define RCD_ADDR_SEL_D 8'h7B
`define RCD_ADDR_PAT_LOW 8'h7C
`define RCD_ADDR_CHG_LIM 8'h7D
`define RCD_ADDR_TAP_LIM 8'h7E
`define RCD_ADDR_ADAPT_CTL 8'h7F
`define RCD_ADDR_EYE_CTR 8'h80
`define RCD_ADDR_CHK_CTL 8'h82
`define RCD_ADDR_ERR_HI 8'h83
`define RCD_ADDR_ERR_LO 8'h84
`define RCD_ADDR_BITS_B5 8'h85
`define RCD_ADDR_BITS_B4 8'h86
`define RCD_ADDR_BITS_B3 8'h87
`define RCD_ADDR_BITS_B2 8'h88
`define RCD_ADDR_BITS_B1 8'h89
`define RCD_ADDR_PAT_HIGH 8'h97
// reset values
`define RCD_RST_EYE_THR 8'h22
`define RCD_RST_SBT_THR 8'h1A
`define RCD_RST_ENABLES 8'h10
`define RCD_RST_CHG_LIM 8'h48
`define RCD_RST_TAP_LIM 8'h13
`define RCD_RST_ADAPT_CTL 8'h3A
`define RCD_RST_CHK_CTL 8'h00
// field positions
`define RCD_EN_CHECKER 6
`define RCD_EN_GENERATOR 5
`define RCD_EN_COMMA 3
`define RCD_EN_LOCK_FLAG 1
`define RCD_EN_SIG_FLAG 0
`define RCD_AC_SKIP_EYE 5
`define RCD_AC_KEEP_ADAPT 4
`define RCD_AC_EITHER_EYE 3
`define RCD_CC_HOLD 7
`define RCD_CC_CLEAR 6
`define RCD_CC_PAT_FORCE 4
`define RCD_CC_POL_FORCE 1
`define RCD_CC_POL_CHOICE 0
// writable bits of the enable register
`define RCD_ENABLES_WMASK 8'h7B
// one threshold step is four eye-opening counts
`define RCD_EYE_STEP_SHIFT 2
`endif

/* core/rcd_pkg.sv */
package rcd_pkg;
  typedef struct packed {
    logic [7:0] horizontal_eye_opening;
    logic [7:0] vertical_eye_opening;
  } rcd_eye_type;
  typedef struct packed {
    logic tap5_polarity_view;
    logic [3:0] tap5_weight_view;
  } rcd_tap5_type;
  typedef struct packed {
    logic checker_on;
    logic pattern_force;
    logic [1:0] pattern_choice;
    logic polarity_force;
    logic polarity_choice;
  } rcd_checker_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcd_req_type;
endpackage : rcd_pkg

/* tb/rcd_diag_regs_assertions.sv */
`timescale 1ns/1ps
module rcd_diag_regs_checker #(
  parameter int ERR_W = 11,
  parameter int BITS_W = 47
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire rcd_pkg::rcd_req_type req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  // pins and observation
  input wire logic signal_present_i,
  input wire logic recovery_locked_i,
  input wire rcd_pkg::rcd_tap5_type tap5_i,
  // controls
  input wire rcd_pkg::rcd_checker_type checker_o,
  input wire logic generator_on_o,
  input wire logic comma_lock_check_on_o,
  input wire logic [15:0] user_pattern_word_o,
  input wire logic adapt_trigger_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // pins must sit still long enough to pass the synchronizer
  sequence pins_steady;
    ($stable(signal_present_i) && $stable(recovery_locked_i)) [*4];
  endsequence
  sequence status_read;
    req_i.rd && req_i.addr == 8'h78;
  endsequence
  sequence tap5_read;
    req_i.rd && req_i.addr == 8'h75;
  endsequence
  a_status_live: assert property (pins_steady ##0 status_read
    |=> rd_data_o[5:4] == $past({signal_present_i, recovery_locked_i}))
    else $error("live status bits wrong");
  a_tap5_view: assert property (($stable(tap5_i) [*2]) ##0 tap5_read
    |=> rd_data_o == {3'h0, $past(tap5_i)})
    else $error("tap view read wrong");
  a_wo_zero: assert property (req_i.rd && req_i.addr inside {8'h7C, 8'h97, 8'h81}
    |=> rd_data_o == 8'h00)
    else $error("write-only byte read not zero");
  a_enable_follow: assert property (req_i.wr && req_i.addr == 8'h79
    |-> ##2 {checker_o.checker_on, generator_on_o, comma_lock_check_on_o}
    == $past({req_i.wdata[6:5], req_i.wdata[3]}, 2))
    else $error("enable outputs do not follow write");
  a_checker_fields: assert property (req_i.wr && req_i.addr == 8'h82 |-> ##2
    checker_o[4:0] == $past(req_i.wdata[4:0], 2))
    else $error("checker fields do not follow write");
  a_pattern_low: assert property (req_i.wr && req_i.addr == 8'h7C |-> ##2
    user_pattern_word_o[7:0] == $past(req_i.wdata, 2))
    else $error("pattern low byte wrong");
  a_read_answer: assert property (req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  a_valid_cause: assert property (rd_valid_o |-> $past(req_i.rd))
    else $error("read valid without read");
  a_trigger_gap: assert property (adapt_trigger_o |=> !adapt_trigger_o)
    else $error("adaption triggers too close");
endmodule : rcd_diag_regs_checker

bind rcd_diag_regs rcd_diag_regs_checker #(.ERR_W(ERR_W), .BITS_W(BITS_W)) chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .signal_present_i(signal_present_i),
  .recovery_locked_i(recovery_locked_i), .tap5_i(tap5_i), .checker_o(checker_o),
  .generator_on_o(generator_on_o), .comma_lock_check_on_o(comma_lock_check_on_o),
  .user_pattern_word_o(user_pattern_word_o), .adapt_trigger_o(adapt_trigger_o));

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  rcd_pkg::rcd_req_type req_i = '0;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic signal_present_i = 1'b0;
  logic recovery_locked_i = 1'b0;
  logic eye_loss_flag_on_i = 1'b0;
  rcd_pkg::rcd_eye_type eye_i = 16'h4040;
  rcd_pkg::rcd_tap5_type tap5_i = '0;
  logic [7:0] eye_center_i = 8'h00;
  logic checker_synced_i = 1'b0;
  logic bit_compared_i = 1'b0;
  logic bit_mismatch_i = 1'b0;
  rcd_pkg::rcd_checker_type checker_o;
  logic generator_on_o, comma_lock_check_on_o, adapt_allowed_o, adapt_trigger_o;
  logic skip_eye_checks_o;
  logic [15:0] user_pattern_word_o;
  logic [2:0] en_view;
  logic [1:0] adapt_view;
  assign en_view = {checker_o.checker_on, generator_on_o, comma_lock_check_on_o};
  assign adapt_view = {adapt_allowed_o, skip_eye_checks_o};
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_trig = 0;
  int n0;
  logic [7:0] expq[$];
  logic [7:0] lfsr_reg = 8'h28;
  localparam logic [7:0] RA [13] = '{8'h76, 8'h77, 8'h79, 8'h7D, 8'h7E, 8'h7F, 8'h82,
    8'h7C, 8'h97, 8'h81, 8'h99, 8'h78, 8'h83};
  localparam logic [7:0] RV [13] = '{8'h22, 8'h1A, 8'h10, 8'h48, 8'h13, 8'h3A, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  rcd_diag_regs rcd_diag_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .signal_present_i(signal_present_i),
    .recovery_locked_i(recovery_locked_i), .eye_loss_flag_on_i(eye_loss_flag_on_i),
    .eye_i(eye_i), .tap5_i(tap5_i), .eye_center_i(eye_center_i),
    .checker_synced_i(checker_synced_i), .bit_compared_i(bit_compared_i),
    .bit_mismatch_i(bit_mismatch_i), .checker_o(checker_o), .generator_on_o(generator_on_o),
    .user_pattern_word_o(user_pattern_word_o), .comma_lock_check_on_o(comma_lock_check_on_o),
    .adapt_allowed_o(adapt_allowed_o), .adapt_trigger_o(adapt_trigger_o),
    .skip_eye_checks_o(skip_eye_checks_o));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch read_data expected %h seen %h", exp, got);
    end
  endtask : chk_rd

  // enable, pattern and first adapt levels are sampled mid-cycle so the edge's updates have landed
  task automatic chk_out(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_out

  task automatic access(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk_i);
    req_i <= '0;
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    access(1'b1, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      bit_compared_i <= 1'b1;
      bit_mismatch_i <= (i % 60 == 0);
    end
    @(posedge clk_i);
    bit_compared_i <= 1'b0;
    bit_mismatch_i <= 1'b0;
  endtask : pulses

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge clk_i) begin
    cycles++;
    if (adapt_trigger_o === 1'b1) n_trig++;
    if (rd_valid_o === 1'b1) begin
      if (expq.size() == 0) begin
        n_mismatch++;
        $display("mismatch read_data expected none seen %h", rd_data_o);
      end else chk_rd(expq.pop_front(), rd_data_o);
    end
    if (cycles == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    idle(16);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 13; i++) rd(RA[i], RV[i]);
    $display("test reset_values done");
    wr(8'h75, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      @(posedge clk_i);
      tap5_i <= lfsr_reg[4:0];
      eye_center_i <= lfsr_next(lfsr_reg);
      idle(2);
      rd(8'h75, {3'h0, lfsr_reg[4:0]});
      rd(8'h80, lfsr_next(lfsr_reg));
    end
    $display("test observation done");
    wr(8'h79, 8'hFF);
    rd(8'h79, 8'h7B);
    @(negedge clk_i);
    chk_out("enables", 16'(en_view), 16'h0007);
    wr(8'h79, 8'h00);
    idle(1);
    @(negedge clk_i);
    chk_out("enables", 16'(en_view), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      wr(8'h82, {3'h0, 1'b1, 2'(k), lfsr_reg[1:0]});
      rd(8'h82, {3'h0, 1'b1, 2'(k), lfsr_reg[1:0]});
      chk_out("checker", 16'({2'b01, 2'(k), lfsr_reg[1:0]}), 16'(checker_o));
    end
    wr(8'h7C, 8'hA5);
    wr(8'h97, 8'h3C);
    idle(1);
    @(negedge clk_i);
    chk_out("pattern", 16'h3CA5, user_pattern_word_o);
    $display("test controls done");
    wr(8'h79, 8'h7B);
    @(posedge clk_i);
    signal_present_i <= 1'b1;
    idle(6);
    rd(8'h78, 8'h24);
    rd(8'h78, 8'h20);
    @(posedge clk_i);
    recovery_locked_i <= 1'b1;
    idle(6);
    rd(8'h78, 8'h38);
    rd(8'h78, 8'h30);
    wr(8'h79, 8'h78);
    @(posedge clk_i);
    signal_present_i <= 1'b0;
    recovery_locked_i <= 1'b0;
    idle(6);
    recovery_locked_i <= 1'b1;
    idle(6);
    rd(8'h78, 8'h10);
    $display("test flags done");
    wr(8'h82, 8'h40);
    wr(8'h82, 8'h00);
    @(posedge clk_i);
    checker_synced_i <= 1'b1;
    pulses(300);
    wr(8'h82, 8'h80);
    pulses(20);
    rd(8'h83, 8'h00);
    rd(8'h84, 8'h05);
    for (int i = 0; i < 4; i++) rd(8'h85 + 8'(i), 8'h00);
    rd(8'h89, 8'h01);
    wr(8'h82, 8'h40);
    idle(2);
    rd(8'h84, 8'h00);
    rd(8'h89, 8'h00);
    $display("test counters done");
    @(negedge clk_i);
    chk_out("adapt", 16'(adapt_view), 16'h0003);
    @(posedge clk_i);
    n0 = n_trig;
    eye_i <= 16'h4A40;
    idle(12);
    chk_out("trigger", 16'(n_trig - n0), 16'h0001);
    wr(8'h7F, 8'h32);
    eye_i <= 16'h4040;
    idle(12);
    chk_out("trigger", 16'(n_trig - n0), 16'h0001);
    eye_i <= 16'h4052;
    idle(12);
    chk_out("trigger", 16'(n_trig - n0), 16'h0002);
    wr(8'h7F, 8'h2A);
    eye_i <= 16'h0840;
    eye_loss_flag_on_i <= 1'b1;
    idle(8);
    chk_out("adapt", 16'(adapt_view), 16'h0000);
    chk_out("trigger", 16'(n_trig - n0), 16'h0002);
    rd(8'h78, 8'h10);
    @(posedge clk_i);
    eye_i <= 16'h0740;
    idle(6);
    rd(8'h78, 8'h11);
    $display("test adaption done");
    idle(4);
    wrap_up();
  end
endmodule : testbench
